// *** dv/sdl_host_model.sv ***
`timescale 1ns/1ps
module sdl_host_model (
	output logic link_clk,
	output logic cs_n,
	output logic din
);
	// clock stands low outside frames, except while idle_toggle runs
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// half-period high keeps duty mid-band
	task automatic send(input logic [31:0] w, input int n);
		#17 cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			din = w[i];
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		#40 cs_n = 1'b1;
		din = ~din;
		// gap well over four mclk so the rise is seen
		#600;
	endtask
	// misuse on purpose: edges with select high
	task automatic idle_toggle(input int n);
		repeat (n) begin
			din = 1'($urandom);
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
	endtask
endmodule

// *** dv/sdl_latch_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sdl_latch_tb;
	logic mclk, arst_n, load_strobe_n, link_clk, cs_n, din;
	logic short_frame, input_ready, overrun;
	logic [sdl_pkg::CODE_W-1:0] dac_code;
	logic [sdl_pkg::SEG_W-1:0] segment_switch;
	logic [sdl_pkg::LAD_W-1:0] ladder_switch;
	int n_errors = 0;
	int comparisons = 0;
	int ovr_seen = 0;
	int ovr_exp = 0;
	int cyc = 0;
	logic [13:0] sreg;
	logic [14:0] q[$];
	logic [14:0] shown = 15'h0000;

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	sdl_host_model host_u (
		.link_clk(link_clk),
		.cs_n(cs_n),
		.din(din)
	);

	sdl_latch dut_u (
		.mclk(mclk),
		.arst_n(arst_n),
		.link_clk(link_clk),
		.cs_n(cs_n),
		.din(din),
		.load_strobe_n(load_strobe_n),
		.dac_code(dac_code),
		.segment_switch(segment_switch),
		.ladder_switch(ladder_switch),
		.short_frame(short_frame),
		.input_ready(input_ready),
		.overrun(overrun)
	);

	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// about 960 cycles expected
	always @(posedge mclk) begin
		cyc++;
		if (overrun === 1'b1) begin
			ovr_seen++;
		end
		if (cyc == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic check();
		logic [14:0] s;
		#1;
		s = 15'h0000;
		for (int i = 0; i < 15; i++) begin
			s[i] = (shown[13:10] > i);
		end
		`CHK(dac_code, shown[13:0])
		`CHK(segment_switch, s)
		`CHK(ladder_switch, shown[9:0])
		`CHK(short_frame, shown[14])
	endtask

	// model: shift register persists, queue keeps oldest, drops when full
	task automatic frame(input logic [31:0] w, input int n);
		host_u.send(w, n);
		for (int i = n - 1; i >= 0; i--) begin
			sreg = {sreg[12:0], w[i]};
		end
		if (q.size() < sdl_pkg::FIFO_DEPTH) begin
			q.push_back({1'(n < 14), sreg});
		end else begin
			ovr_exp++;
		end
	endtask

	// a held strobe drains to the newest word
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		if (!load_strobe_n && q.size() > 0) begin
			shown = q[$];
			q.delete();
		end
		check();
	endtask

	initial begin
		void'($urandom(96665));
		arst_n = 1'b0;
		load_strobe_n = 1'b0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		check();
		repeat (3) @(posedge mclk);
		// first word full length: shift register starts unknown
		for (int k = 0; k < 16; k++) begin
			frame({18'h0, 4'(k), 10'($urandom)}, 14);
			settle(14);
		end
		frame(32'($urandom), 18);
		settle(14);
		frame(32'($urandom), 5);
		settle(14);
		host_u.idle_toggle(20);
		settle(4);
		@(posedge mclk);
		load_strobe_n <= 1'b1;
		for (int k = 0; k < 9; k++) begin
			frame(32'($urandom), 14);
		end
		settle(6);
		`CHK(input_ready, 1'b0)
		`CHK(ovr_seen, ovr_exp)
		@(posedge mclk);
		load_strobe_n <= 1'b0;
		settle(14);
		`CHK(input_ready, 1'b1)
		print_verdict();
	end
endmodule

// *** verilog/sdl_fifo.sv ***
`timescale 1ns/1ps
module sdl_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop && !push) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	fifo_bound_a: assert property (@(posedge mclk) disable iff (!arst_n)
		count_reg <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");

endmodule

// *** verilog/sdl_latch.sv ***
`timescale 1ns/1ps
module sdl_latch (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic load_strobe_n,
	output logic [sdl_pkg::CODE_W-1:0] dac_code,
	output logic [sdl_pkg::SEG_W-1:0] segment_switch,
	output logic [sdl_pkg::LAD_W-1:0] ladder_switch,
	output logic short_frame,
	output logic input_ready,
	output logic overrun
);

	// link domain
	logic [sdl_pkg::CODE_W-1:0] shift_reg;
	logic [sdl_pkg::CNT_W-1:0] bit_count_reg;
	logic frame_open_reg;
	logic [sdl_pkg::CNT_W-1:0] fill_count_reg;

	// system domain
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_last_reg;
	logic load_meta_reg;
	logic load_sync_n_reg;
	logic cs_rise;
	logic push_valid_reg;
	sdl_pkg::sdl_word_type push_word_reg;
	sdl_pkg::sdl_word_type pop_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic pop;
	logic [sdl_pkg::CODE_W-1:0] dac_code_reg;
	logic [sdl_pkg::SEG_W-1:0] segment_switch_reg;
	logic [sdl_pkg::LAD_W-1:0] ladder_switch_reg;
	logic short_frame_reg;
	logic input_ready_reg;
	logic overrun_reg;
	logic loaded_once_reg;

	function automatic logic [sdl_pkg::SEG_W-1:0] therm(input logic [sdl_pkg::SEG_SEL_W-1:0] v);
		logic [sdl_pkg::SEG_W-1:0] t;
		t = '0;
		for (int i = 0; i < sdl_pkg::SEG_W; i++) begin
			t[i] = (32'(v) > i);
		end
		therm = t;
	endfunction

	// shift register has no reset at all: contents are junk until a full word
	always_ff @(posedge link_clk) begin
		if (!cs_n) begin
			shift_reg <= {shift_reg[sdl_pkg::CODE_W-2:0], din};
		end
	end

	// set while deselected so the first edge of a frame restarts the count;
	// count is never cleared by select, so it is still stable when read
	always_ff @(posedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			frame_open_reg <= 1'b1;
		end else begin
			frame_open_reg <= 1'b0;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_count_reg <= sdl_pkg::CNT_RESET;
		end else if (!cs_n) begin
			if (frame_open_reg) begin
				bit_count_reg <= sdl_pkg::CNT_FIRST;
			end else if (bit_count_reg != sdl_pkg::WORD_BITS) begin
				bit_count_reg <= bit_count_reg + 1'b1;
			end
		end
	end

	// assertion helper: counts shifts since reset, so the msb-first check
	// skips the first frame, whose upper bits are still unknown
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			fill_count_reg <= sdl_pkg::CNT_RESET;
		end else if (!cs_n && fill_count_reg != sdl_pkg::WORD_BITS) begin
			fill_count_reg <= fill_count_reg + 1'b1;
		end
	end

	// select and strobe are pins: two flops before any logic
	// flops reset to the idle high level so no false rise follows reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_last_reg <= 1'b1;
		end else begin
			cs_meta_reg <= cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_last_reg <= cs_sync_reg;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			load_meta_reg <= 1'b1;
			load_sync_n_reg <= 1'b1;
		end else begin
			load_meta_reg <= load_strobe_n;
			load_sync_n_reg <= load_meta_reg;
		end
	end

	assign cs_rise = cs_sync_reg & ~cs_last_reg;

	// word crosses as stable data: the shift register holds once select is high,
	// and the capture waits one system edge behind the synchronised select
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			push_valid_reg <= 1'b0;
			push_word_reg <= '0;
		end else begin
			push_valid_reg <= cs_rise;
			if (cs_rise) begin
				push_word_reg.code <= shift_reg;
				push_word_reg.short_frame <= (bit_count_reg != sdl_pkg::WORD_BITS);
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			overrun_reg <= 1'b0;
			input_ready_reg <= 1'b0;
		end else begin
			// dropping the newest word keeps the queued codes intact
			overrun_reg <= push_valid_reg & ~fifo_in_ready;
			input_ready_reg <= fifo_in_ready;
		end
	end

	// queue absorbs frames that finish while the strobe is held high
	sdl_fifo #(
		.WIDTH(sdl_pkg::WORD_W),
		.DEPTH(sdl_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_valid(push_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(push_word_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(pop_word)
	);

	// strobe held low drains one word per cycle, so a held or tied-low strobe
	// ends on the newest word; a strobe shorter than the sync misses
	assign fifo_out_ready = ~load_sync_n_reg;
	assign pop = fifo_out_valid & fifo_out_ready;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dac_code_reg <= sdl_pkg::CODE_RESET;
			segment_switch_reg <= sdl_pkg::SEG_RESET;
			ladder_switch_reg <= sdl_pkg::LAD_RESET;
			short_frame_reg <= 1'b0;
		end else if (pop) begin
			dac_code_reg <= pop_word.code;
			segment_switch_reg <= therm(pop_word.code[sdl_pkg::CODE_W-1:sdl_pkg::SEG_LSB]);
			ladder_switch_reg <= pop_word.code[sdl_pkg::LAD_W-1:0];
			short_frame_reg <= pop_word.short_frame;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			loaded_once_reg <= 1'b0;
		end else if (pop) begin
			loaded_once_reg <= 1'b1;
		end
	end

	assign dac_code = dac_code_reg;
	assign segment_switch = segment_switch_reg;
	assign ladder_switch = ladder_switch_reg;
	assign short_frame = short_frame_reg;
	assign input_ready = input_ready_reg;
	assign overrun = overrun_reg;

	// link domain checks
	shift_msb_first_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		!cs_n && fill_count_reg == sdl_pkg::WORD_BITS
		|=> shift_reg == {$past(shift_reg[sdl_pkg::CODE_W-2:0]), $past(din)})
		else $error("shift register did not take din at lsb");

	shift_lsb_take_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		!cs_n |=> shift_reg[0] == $past(din))
		else $error("shift register lsb missed din");

	frame_start_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		frame_open_reg && !cs_n |=> bit_count_reg == sdl_pkg::CNT_FIRST)
		else $error("bit count did not restart at frame start");

	count_idle_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		cs_n |=> $stable(bit_count_reg))
		else $error("bit count moved while deselected");

	frame_idle_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		cs_n |-> frame_open_reg)
		else $error("frame flag not set while deselected");

	count_sat_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		!cs_n && !frame_open_reg && bit_count_reg == sdl_pkg::WORD_BITS
		|=> bit_count_reg == sdl_pkg::WORD_BITS)
		else $error("bit count left full word in long frame");

	shift_idle_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		cs_n |=> $stable(shift_reg))
		else $error("shift register moved while deselected");

	count_limit_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		bit_count_reg <= sdl_pkg::WORD_BITS)
		else $error("bit count above word length");

	// system domain checks
	reset_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!loaded_once_reg |-> dac_code_reg == sdl_pkg::CODE_RESET)
		else $error("latch not zero before first load");

	reset_seg_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!loaded_once_reg
		|-> segment_switch_reg == sdl_pkg::SEG_RESET && ladder_switch_reg == sdl_pkg::LAD_RESET)
		else $error("switches not at reset before first load");

	word_capture_a: assert property (@(posedge mclk) disable iff (!arst_n)
		cs_rise |=> push_word_reg.code == $past(shift_reg))
		else $error("select rise did not capture shift register");

	short_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pop |=> short_frame_reg == $past(pop_word.short_frame))
		else $error("short flag did not follow queued word");

	ladder_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!pop |=> $stable(ladder_switch_reg) && $stable(short_frame_reg))
		else $error("ladder or flag changed without update");

	overrun_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
		overrun_reg |=> !overrun_reg)
		else $error("overrun held longer than one cycle");

	load_copies_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pop |=> dac_code_reg == $past(pop_word.code))
		else $error("latch did not take queued word");

	latch_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!pop |=> $stable(dac_code_reg) && $stable(segment_switch_reg))
		else $error("latch changed without update");

	strobe_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
		load_sync_n_reg |=> $stable(dac_code_reg))
		else $error("latch changed with strobe high");

	segment_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
		segment_switch_reg == therm(dac_code_reg[sdl_pkg::CODE_W-1:sdl_pkg::SEG_LSB]))
		else $error("segment switches disagree with code");

	ladder_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ladder_switch_reg == dac_code_reg[sdl_pkg::LAD_W-1:0])
		else $error("ladder switches disagree with code");

	frame_push_a: assert property (@(posedge mclk) disable iff (!arst_n)
		cs_rise |=> push_valid_reg ##1 (fifo_out_valid || overrun_reg))
		else $error("select rise did not queue a word");

	idle_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(cs_sync_reg && cs_last_reg && !push_valid_reg && !fifo_out_valid)
		|=> $stable(dac_code_reg))
		else $error("latch changed while deselected and idle");

	full_word_c: cover property (@(posedge mclk) disable iff (!arst_n)
		pop && !pop_word.short_frame);
	short_word_c: cover property (@(posedge mclk) disable iff (!arst_n)
		pop && pop_word.short_frame);
	queue_full_c: cover property (@(posedge mclk) disable iff (!arst_n)
		!fifo_in_ready);
	overrun_c: cover property (@(posedge mclk) disable iff (!arst_n)
		overrun_reg);
	deselect_edge_c: cover property (@(posedge link_clk) disable iff (!arst_n)
		cs_n);

endmodule

// *** verilog/sdl_pkg.sv ***
package sdl_pkg;

	// code and switch geometry
	localparam int CODE_W = 14;
	localparam int SEG_SEL_W = 4;
	localparam int SEG_W = 15;
	localparam int LAD_W = 10;
	localparam int SEG_LSB = 10;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] WORD_BITS = 4'he;
	localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

	// power-on value of the converter latch: zero scale
	localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
	localparam logic [SEG_W-1:0] SEG_RESET = 15'h0000;
	localparam logic [LAD_W-1:0] LAD_RESET = 10'h000;

	// word queue between link and latch
	localparam int FIFO_DEPTH = 8;

	// system clock and least load strobe width
	localparam int MCLK_PERIOD_NS = 100;
	localparam int LOAD_MIN_NS = 30;
	localparam int LOAD_MIN_CYC_RAW = (LOAD_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int LOAD_MIN_CYC = (LOAD_MIN_CYC_RAW < 1) ? 1 : LOAD_MIN_CYC_RAW;

	typedef struct packed {
		logic short_frame;
		logic [CODE_W-1:0] code;
	} sdl_word_type;

	localparam int WORD_W = $bits(sdl_word_type);

endpackage
